// file: verilog/sfcf_frontend.sv
// Serial slave command front end: mode detect, opcode decode, write latch, status
`timescale 1ns/1ns
`default_nettype none
module sfcf_frontend
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        csN,
    input  wire logic        sck,
    input  wire logic        si,
    output logic             so,
    output logic             soOe,
    output logic             writeLatchFlag,
    output logic             protectSelLo,
    output logic             protectSelHi,
    output logic             addrValid,
    output logic [8:0]       memAddr,
    output logic             memIsWrite,
    output logic             wrByteValid,
    output logic [7:0]       wrByte
);
    import sfcf_pkg::*;

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        sfcf_state_e state;
        logic        csPrev;
        logic        sckPrev;
        logic        modeHigh;
        logic        sawLow;
        logic [2:0]  bitCnt;
        logic [7:0]  shiftIn;
        logic        addrTop;
        logic        clearAtEnd;
        logic        writeLatchFlag;
        logic        protectSelLo;
        logic        protectSelHi;
        logic        soArm;
        logic [7:0]  soShift;
        logic        so;
        logic        soOe;
        logic        addrValid;
        logic [8:0]  memAddr;
        logic        memIsWrite;
        logic        wrByteValid;
        logic [7:0]  wrByte;
    } sfcf_front_s;

    sfcf_front_s s;
    sfcf_front_s nxt_s;

    sfcf_pin_if pins ();

    sfcf_pin_sync u_sync
    (
        .clk    (clk),
        .srst   (srst),
        .ce     (ce),
        .csNRaw (csN),
        .sckRaw (sck),
        .siRaw  (si),
        .pins   (pins.src)
    );

    // ********************************************************************
    // Edge detection on the synchronised pins
    // ********************************************************************
    logic       csFall;
    logic       csRise;
    logic       sckRise;
    logic       sckFall;
    logic       sampling;
    logic       byteDone;
    logic [7:0] shiftNext;
    logic [7:0] statusByte;

    assign csFall  = s.csPrev & ~pins.csN;
    assign csRise  = ~s.csPrev & pins.csN;
    assign sckRise = ~s.sckPrev & pins.sck;
    assign sckFall = s.sckPrev & ~pins.sck;

    // Idle-high clock in mode 3 is not an edge until it has been low once
    assign sampling = ~pins.csN & ~csFall & sckRise & s.sawLow
                    & (s.state != ST_IDLE) & (s.state != ST_DONE)
                    & (s.state != ST_IGNORE);

    assign shiftNext = {s.shiftIn[6:0], pins.si};
    assign byteDone  = (s.bitCnt == LAST_BIT);

    // Unused status bits are tied to zero and cannot be written
    always_comb
    begin
        statusByte                   = 8'h00;
        statusByte[STAT_LATCH_POS]   = s.writeLatchFlag;
        statusByte[STAT_PROT_LO_POS] = s.protectSelLo;
        statusByte[STAT_PROT_HI_POS] = s.protectSelHi;
    end

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb
    begin
        nxt_s             = s;
        nxt_s.addrValid   = 1'b0;
        nxt_s.wrByteValid = 1'b0;
        nxt_s.csPrev      = pins.csN;
        nxt_s.sckPrev     = pins.sck;

        if (csFall)
        begin
            nxt_s.state      = ST_OPCODE;
            nxt_s.modeHigh   = pins.sck;
            nxt_s.sawLow     = ~pins.sck;
            nxt_s.bitCnt     = 3'h0;
            nxt_s.shiftIn    = 8'h00;
            nxt_s.soArm      = 1'b0;
            nxt_s.clearAtEnd = 1'b0;
            nxt_s.memIsWrite = 1'b0;
        end
        else if (pins.csN)
        begin
            // Deselected: input ignored, output released
            nxt_s.state      = ST_IDLE;
            nxt_s.soOe       = 1'b0;
            nxt_s.soArm      = 1'b0;
            nxt_s.memIsWrite = 1'b0;
            nxt_s.clearAtEnd = 1'b0;
            if (csRise && s.clearAtEnd)
            begin
                nxt_s.writeLatchFlag = 1'b0;
            end
        end
        else
        begin
            if (!pins.sck)
            begin
                nxt_s.sawLow = 1'b1;
            end

            if (sampling)
            begin
                nxt_s.shiftIn = shiftNext;
                nxt_s.bitCnt  = s.bitCnt + 3'h1;
                if (byteDone)
                begin
                    case (s.state)
                        ST_OPCODE:
                        begin
                            // First byte of the selection is the opcode
                            nxt_s.state = ST_DONE;
                            if (shiftNext == OPC_SET_LATCH)
                            begin
                                nxt_s.writeLatchFlag = 1'b1;
                            end
                            else if (shiftNext == OPC_CLR_LATCH)
                            begin
                                nxt_s.clearAtEnd = 1'b1;
                            end
                            else if (shiftNext == OPC_STATUS_RD)
                            begin
                                nxt_s.soShift = statusByte;
                                nxt_s.soArm   = 1'b1;
                            end
                            else if (shiftNext == OPC_STATUS_WR)
                            begin
                                nxt_s.state      = ST_STATUS_WR;
                                nxt_s.clearAtEnd = 1'b1;
                            end
                            else if (shiftNext[7:4] == OPC_MEM_HIGH
                                     && (shiftNext[2:0] == OPC_MEM_RD_LOW
                                     || shiftNext[2:0] == OPC_MEM_WR_LOW))
                            begin
                                nxt_s.state      = ST_ADDR;
                                nxt_s.addrTop    = shiftNext[ADDR_TOP_POS];
                                nxt_s.memIsWrite = (shiftNext[2:0] == OPC_MEM_WR_LOW);
                                nxt_s.clearAtEnd = (shiftNext[2:0] == OPC_MEM_WR_LOW);
                            end
                            else
                            begin
                                nxt_s.state = ST_IGNORE;
                            end
                        end
                        ST_ADDR:
                        begin
                            nxt_s.memAddr   = {s.addrTop, shiftNext};
                            nxt_s.addrValid = 1'b1;
                            nxt_s.state     = ST_MEMDATA;
                        end
                        ST_STATUS_WR:
                        begin
                            // Latch bit is never taken from the written byte
                            if (s.writeLatchFlag)
                            begin
                                nxt_s.protectSelLo = shiftNext[STAT_PROT_LO_POS];
                                nxt_s.protectSelHi = shiftNext[STAT_PROT_HI_POS];
                            end
                            nxt_s.state = ST_DONE;
                        end
                        ST_MEMDATA:
                        begin
                            // Bytes of a write that was never enabled stop here
                            if (s.memIsWrite && s.writeLatchFlag)
                            begin
                                nxt_s.wrByte      = shiftNext;
                                nxt_s.wrByteValid = 1'b1;
                            end
                        end
                        default:
                        begin
                            nxt_s.state = ST_IGNORE;
                        end
                    endcase
                end
            end

            // Status byte repeats while the master keeps clocking
            if (sckFall && s.soArm)
            begin
                nxt_s.soOe    = 1'b1;
                nxt_s.so      = s.soShift[7];
                nxt_s.soShift = {s.soShift[6:0], s.soShift[7]};
            end
        end
    end

    // ********************************************************************
    // Registers
    // ********************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s                <= '0;
            s.state          <= ST_IDLE;
            s.csPrev         <= CS_IDLE;
            s.writeLatchFlag <= LATCH_RST;
            s.protectSelLo   <= PROTECT_RST[0];
            s.protectSelHi   <= PROTECT_RST[1];
        end
        else if (ce)
        begin
            s <= nxt_s;
        end
    end

    assign so             = s.so;
    assign soOe           = s.soOe;
    assign writeLatchFlag = s.writeLatchFlag;
    assign protectSelLo   = s.protectSelLo;
    assign protectSelHi   = s.protectSelHi;
    assign addrValid      = s.addrValid;
    assign memAddr        = s.memAddr;
    assign memIsWrite     = s.memIsWrite;
    assign wrByteValid    = s.wrByteValid;
    assign wrByte         = s.wrByte;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cbFront @(posedge clk);
    endclocking

    default disable iff (srst);

    sequence seqDeselect;
        (ce && pins.csN) ##1 ce;
    endsequence

    sequence seqOpcodeByte(logic [7:0] code);
        ce && sampling && byteDone && s.state == ST_OPCODE && shiftNext == code;
    endsequence

    AST_SO_ON_FALL: assert property (
        $changed(s.so) |-> $past(sckFall && ce)
    ) else $error("serial output changed without a falling clock");

    AST_MODE_CAPTURE: assert property (
        (ce && csFall) |=> (s.modeHigh == $past(pins.sck)) && s.state == ST_OPCODE
    ) else $error("clock mode not captured at select");

    AST_MODE3_IDLE_EDGE: assert property (
        (ce && s.state == ST_OPCODE && !s.sawLow && !pins.csN && !csFall)
        |=> s.bitCnt == $past(s.bitCnt)
    ) else $error("idle-high clock counted as a sampling edge");

    AST_DESELECT_QUIET: assert property (
        seqDeselect |-> !s.soOe && s.state == ST_IDLE
    ) else $error("output driven while deselected");

    AST_SET_LATCH: assert property (
        seqOpcodeByte(OPC_SET_LATCH) |=> s.writeLatchFlag ##1 (s.state == ST_DONE || pins.csN)
    ) else $error("set-latch command did not set the latch");

    AST_CLEAR_AT_RISE: assert property (
        (ce && csRise && s.clearAtEnd) |=> !s.writeLatchFlag
    ) else $error("write latch not cleared at deselect");

    AST_STATUS_WR_LATCH: assert property (
        (ce && sampling && byteDone && s.state == ST_STATUS_WR)
        |=> s.writeLatchFlag == $past(s.writeLatchFlag)
    ) else $error("status write altered the latch");

    AST_STATUS_FIRST_BIT: assert property (
        $rose(s.soOe) |-> $past(sckFall) && !s.so && s.state == ST_DONE
    ) else $error("status output started off a falling edge or top bit set");

    AST_BAD_OPCODE: assert property (
        (s.state == ST_IGNORE) |-> !s.soOe ##1 (s.state == ST_IGNORE || s.state == ST_IDLE)
    ) else $error("unknown opcode left ignore state while selected");

    AST_ADDR_TOP: assert property (
        s.addrValid |-> s.memAddr[8] == s.addrTop && s.state == ST_MEMDATA
    ) else $error("address top bit not taken from opcode");

    AST_POWERUP_LATCH: assert property (
        $fell(srst) |-> !s.writeLatchFlag
    ) else $error("write latch set after reset");

    AST_WRITE_NEEDS_LATCH: assert property (
        s.wrByteValid |-> $past(s.writeLatchFlag)
    ) else $error("data byte passed on without the write latch");

    AST_STATUS_ZERO_BITS: assert property (
        seqOpcodeByte(OPC_STATUS_RD) |=> s.soShift[7:4] == 4'h0 && !s.soShift[0]
    ) else $error("fixed status bits not zero");

    AST_DESELECT_NO_SAMPLE: assert property (
        (ce && pins.csN) |=> s.bitCnt == $past(s.bitCnt) && s.shiftIn == $past(s.shiftIn)
    ) else $error("serial input sampled while deselected");

    AST_SELECT_RESTART: assert property (
        (ce && csFall) |=> s.bitCnt == 3'h0 && s.shiftIn == 8'h00
    ) else $error("bit counter or opcode shifter not restarted at select");

    AST_MEM_WR_DECODE: assert property (
        seqOpcodeByte({OPC_MEM_HIGH, 1'b1, OPC_MEM_WR_LOW})
        |=> s.memIsWrite && s.addrTop && s.state == ST_ADDR
    ) else $error("memory write opcode or address top bit not decoded");

    AST_CLEAR_CMD: assert property (
        seqOpcodeByte(OPC_CLR_LATCH)
        |=> s.clearAtEnd && s.state == ST_DONE
    ) else $error("clear-latch command not armed for deselect");

endmodule
`default_nettype wire

// file: verilog/sfcf_pkg.sv
// Constants, types and reset values of the serial memory command front end
package sfcf_pkg;

    // ********************************************************************
    // Opcodes
    // ********************************************************************
    localparam logic [7:0] OPC_SET_LATCH  = 8'h06;
    localparam logic [7:0] OPC_CLR_LATCH  = 8'h04;
    localparam logic [7:0] OPC_STATUS_RD  = 8'h05;
    localparam logic [7:0] OPC_STATUS_WR  = 8'h01;
    localparam logic [3:0] OPC_MEM_HIGH   = 4'h0;
    localparam logic [2:0] OPC_MEM_RD_LOW = 3'h3;
    localparam logic [2:0] OPC_MEM_WR_LOW = 3'h2;
    localparam int         ADDR_TOP_POS   = 3;

    // ********************************************************************
    // Status byte layout, reset values and last bit index
    // ********************************************************************
    localparam int          STAT_LATCH_POS   = 1;
    localparam int          STAT_PROT_LO_POS = 2;
    localparam int          STAT_PROT_HI_POS = 3;
    localparam logic        LATCH_RST        = 1'b0;
    localparam logic [1:0]  PROTECT_RST      = 2'h0;
    localparam logic        CS_IDLE          = 1'b1;
    localparam logic [2:0]  SYNC_RST         = 3'h4;
    localparam logic [2:0]  LAST_BIT         = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_ADDR,
        ST_MEMDATA,
        ST_STATUS_WR,
        ST_DONE,
        ST_IGNORE
    } sfcf_state_e;

endpackage

// file: verilog/sfcf_pin_if.sv
// Synchronised serial pins passed from the synchroniser to the front end
`timescale 1ns/1ns
`default_nettype none
interface sfcf_pin_if;
    logic csN;
    logic sck;
    logic si;

    modport src
    (
        output csN,
        output sck,
        output si
    );

    modport dst
    (
        input  csN,
        input  sck,
        input  si
    );
endinterface
`default_nettype wire

// file: verilog/sfcf_pin_sync.sv
// Two-stage synchroniser for the chip select, serial clock and serial input pins
`timescale 1ns/1ns
`default_nettype none
module sfcf_pin_sync
(
    input  wire logic  clk,
    input  wire logic  srst,
    input  wire logic  ce,
    input  wire logic  csNRaw,
    input  wire logic  sckRaw,
    input  wire logic  siRaw,
    sfcf_pin_if.src    pins
);
    import sfcf_pkg::*;

    typedef struct packed {
        logic [2:0] stage1;
        logic [2:0] stage2;
    } sfcf_sync_s;

    sfcf_sync_s s;
    sfcf_sync_s nxt_s;

    // All three pins share one delay so data stays aligned with its clock edge
    always_comb
    begin
        nxt_s        = s;
        nxt_s.stage1 = {csNRaw, sckRaw, siRaw};
        nxt_s.stage2 = s.stage1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s.stage1 <= SYNC_RST;
            s.stage2 <= SYNC_RST;
        end
        else if (ce)
        begin
            s <= nxt_s;
        end
    end

    assign pins.csN = s.stage2[2];
    assign pins.sck = s.stage2[1];
    assign pins.si  = s.stage2[0];
endmodule
`default_nettype wire

// file: testbench/sfcf_spi_master.sv
// Serial bus master model that drives the front end's pins
`timescale 1ns/1ns
`default_nettype none
module sfcf_spi_master
(
    input  wire logic clk,
    input  wire logic so,
    input  wire logic soOe,
    output logic      csN,
    output logic      sck,
    output logic      si
);
    // Clk cycles per serial half period, giving the 32 ns link period
    localparam int HALF = 4;
    logic idleHigh;

    initial
    begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        idleHigh = 1'b0;
    end

    task automatic waitc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ****************************************************************
    // One selection: start, top n bits per transfer, stop
    // ****************************************************************
    task automatic start(input logic mode3);
        begin
            idleHigh = mode3;
            waitc(2);
            sck = mode3;
            waitc(HALF);
            csN = 1'b0;
            waitc(HALF);
        end
    endtask

    // Sends the top n bits of dout; an undriven output reads as unknown
    task automatic xferBits(input int n, input logic [7:0] dout, output logic [7:0] din);
        int i;
        begin
            din = 8'h00;
            for (i = 0; i < n; i++)
            begin
                sck = 1'b0;
                si = dout[7-i];
                waitc(HALF);
                sck = 1'b1;
                din = {din[6:0], (soOe === 1'b1) ? so : 1'bx};
                waitc(HALF);
            end
        end
    endtask

    task automatic stop();
        begin
            if (!idleHigh)
                sck = 1'b0;
            waitc(HALF);
            csN = 1'b1;
            // Released data line must not keep showing a stale bit
            si = ~si;
            waitc(8);
        end
    endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the serial memory command front end
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sfcf_pkg::*;
    logic       clk;
    logic       srst;
    logic       ce;
    logic       csN;
    logic       sck;
    logic       si;
    logic       so;
    logic       soOe;
    logic       writeLatchFlag;
    logic       protectSelLo;
    logic       protectSelHi;
    logic       addrValid;
    logic [8:0] memAddr;
    logic       memIsWrite;
    logic       wrByteValid;
    logic [7:0] wrByte;
    int         fail_count;
    int         comparisons;
    int         addrCnt;
    int         soBad;
    int         j;
    logic [8:0] addrSeen;
    logic       writeSeen;
    logic       oeSeen;
    logic       soPrev;
    logic [7:0] rd;
    logic [7:0] wrQ[$];
    logic [7:0] badOps[3] = '{8'h07, 8'h8a, 8'hff};

    sfcf_frontend DUT
    (
        .clk(clk), .srst(srst), .ce(ce), .csN(csN), .sck(sck), .si(si), .so(so),
        .soOe(soOe), .writeLatchFlag(writeLatchFlag), .protectSelLo(protectSelLo),
        .protectSelHi(protectSelHi), .addrValid(addrValid), .memAddr(memAddr),
        .memIsWrite(memIsWrite), .wrByteValid(wrByteValid), .wrByte(wrByte)
    );

    sfcf_spi_master u_master
    (
        .clk(clk), .so(so), .soOe(soOe), .csN(csN), .sck(sck), .si(si)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****************************************************************
    // Monitor of pulses and of output timing
    // ****************************************************************
    // Falling edge: registered outputs have settled half a cycle earlier
    always @(negedge clk)
    begin
        if (addrValid === 1'b1)
        begin
            addrCnt++;
            addrSeen = memAddr;
            writeSeen = memIsWrite;
        end
        if (wrByteValid === 1'b1)
            wrQ.push_back(wrByte);
        if (soOe === 1'b1)
            oeSeen = 1'b1;
        // Output may only move while the serial clock is low
        if (soOe === 1'b1 && csN === 1'b0 && sck === 1'b1 && so !== soPrev)
            soBad++;
        soPrev = so;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        begin
            comparisons++;
            if (seen !== exp)
            begin
                fail_count++;
                $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    task automatic clr();
        begin
            addrCnt = 0;
            oeSeen = 1'b0;
            wrQ.delete();
        end
    endtask

    task automatic frame(input logic mode3, input logic [31:0] b, input int nb,
                         output logic [7:0] r);
        int k;
        begin
            clr();
            u_master.start(mode3);
            for (k = 0; k < nb; k++)
                u_master.xferBits(8, b[31-8*k -: 8], r);
            u_master.stop();
        end
    endtask

    task automatic statusIs(input logic mode3, input logic [7:0] exp);
        logic [7:0] r;
        begin
            frame(mode3, {OPC_STATUS_RD, 24'h0}, 2, r);
            check("status byte", r, exp);
            check("output enabled", oeSeen, 1'b1);
        end
    endtask

    task automatic results();
        begin
            $display("comparisons %0d fail_count %0d", comparisons, fail_count);
            if (fail_count == 0 && comparisons > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results();
    end

    initial
    begin
        fail_count = 0;
        comparisons = 0;
        soBad = 0;
        soPrev = 1'b0;
        clr();
        srst = 1'b1;
        ce = 1'b1;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        repeat (10) @(negedge clk);
        check("latch", writeLatchFlag, 1'b0);
        check("protect", {protectSelHi, protectSelLo}, PROTECT_RST);
        check("soOe idle", soOe, 1'b0);
        statusIs(1'b0, 8'h00);
        frame(1'b0, {OPC_STATUS_WR, 8'h0c, 16'h0}, 2, rd);
        check("refused write", {protectSelHi, protectSelLo}, 2'h0);
        frame(1'b1, {OPC_SET_LATCH, 24'h0}, 1, rd);
        check("latch set", writeLatchFlag, 1'b1);
        statusIs(1'b1, 8'h02);
        u_master.start(1'b0);
        u_master.xferBits(8, OPC_STATUS_WR, rd);
        u_master.xferBits(8, 8'hf5, rd);
        u_master.waitc(8);
        check("latch kept", writeLatchFlag, 1'b1);
        u_master.stop();
        check("latch cleared", writeLatchFlag, 1'b0);
        check("protect", {protectSelHi, protectSelLo}, 2'h1);
        statusIs(1'b0, 8'h04);
        frame(1'b0, {OPC_SET_LATCH, 24'h0}, 1, rd);
        frame(1'b0, {OPC_CLR_LATCH, 24'h0}, 1, rd);
        check("latch clear cmd", writeLatchFlag, 1'b0);
        frame(1'b0, {OPC_STATUS_WR, 8'h08, 16'h0}, 2, rd);
        check("write disabled", {protectSelHi, protectSelLo}, 2'h1);
        frame(1'b0, {OPC_MEM_HIGH, 1'b0, OPC_MEM_WR_LOW, 8'h10, 8'h55, 8'h00}, 4, rd);
        check("refused bytes", wrQ.size(), 0);
        frame(1'b0, {OPC_SET_LATCH, 24'h0}, 1, rd);
        frame(1'b0, {OPC_MEM_HIGH, 1'b1, OPC_MEM_WR_LOW, 8'h5a, 8'hc3, 8'h3c}, 4, rd);
        check("addr count", addrCnt, 1);
        check("write addr", addrSeen, 9'h15a);
        check("write kind", writeSeen, 1'b1);
        check("byte count", wrQ.size(), 2);
        check("byte 0", wrQ[0], 8'hc3);
        check("byte 1", wrQ[1], 8'h3c);
        check("latch after write", writeLatchFlag, 1'b0);
        check("write kind off", memIsWrite, 1'b0);
        frame(1'b0, {OPC_MEM_HIGH, 1'b0, OPC_MEM_RD_LOW, 8'h01, 16'hffff}, 3, rd);
        check("read addr", addrSeen, 9'h001);
        check("read kind", writeSeen, 1'b0);
        check("read no bytes", wrQ.size(), 0);
        for (j = 0; j < 3; j++)
        begin
            frame(1'b0, {badOps[j], OPC_SET_LATCH, OPC_STATUS_RD, 8'h0a}, 4, rd);
            check("bad op latch", writeLatchFlag, 1'b0);
            check("bad op oe", oeSeen, 1'b0);
            check("bad op addr", addrCnt, 0);
        end
        u_master.start(1'b0);
        u_master.xferBits(5, 8'h00, rd);
        u_master.stop();
        frame(1'b0, {OPC_SET_LATCH, 24'h0}, 1, rd);
        check("fresh opcode", writeLatchFlag, 1'b1);
        frame(1'b0, {OPC_CLR_LATCH, 24'h0}, 1, rd);
        clr();
        u_master.xferBits(8, OPC_SET_LATCH, rd);
        u_master.waitc(8);
        check("deselected latch", writeLatchFlag, 1'b0);
        check("deselected oe", oeSeen, 1'b0);
        statusIs(1'b0, 8'h04);
        // A frame sent while the clock enable is low must leave no trace
        ce = 1'b0;
        frame(1'b0, {OPC_SET_LATCH, 24'h0}, 1, rd);
        ce = 1'b1;
        u_master.waitc(8);
        check("frozen latch", writeLatchFlag, 1'b0);
        frame(1'b0, {OPC_SET_LATCH, 24'h0}, 1, rd);
        check("latch before reset", writeLatchFlag, 1'b1);
        srst = 1'b1;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge clk);
        check("reset latch", writeLatchFlag, LATCH_RST);
        check("reset protect", {protectSelHi, protectSelLo}, PROTECT_RST);
        statusIs(1'b0, 8'h00);
        check("so edge", soBad, 0);
        results();
    end
endmodule
`default_nettype wire
